// ---- rtl/bcl_pkg.sv ----
package bcl_pkg;

    // =====================================================================
    // Sizes and timing
    localparam int          MEM_WORDS    = 256;
    localparam int          ROM_BYTES    = 1024;
    localparam logic [10:0] ROM_LAST     = 11'h400;
    localparam logic [7:0]  MEM_LAST     = 8'hff;
    localparam logic [1:0]  CFG_SAMPLE_N = 2'h2;
    localparam int          HP_CTRL_BIT  = 0;

    // =====================================================================
    // Far end register map (word offsets on the Avalon slave)
    localparam logic [2:0] REG_CTRL  = 3'h0;
    localparam logic [2:0] REG_CFG   = 3'h1;
    localparam logic [2:0] REG_ADDR  = 3'h2;
    localparam logic [2:0] REG_WDATA = 3'h3;
    localparam logic [2:0] REG_RDATA = 3'h4;
    localparam logic [2:0] REG_STAT  = 3'h5;
    localparam logic [2:0] REG_ROM   = 3'h6;

    localparam int CTRL_HP_WRITE = 0;
    localparam int CTRL_HP_READ  = 1;
    localparam int CTRL_HP_CREG  = 2;
    localparam int CTRL_EMU_SET  = 3;

    localparam int CFG_BOOT_LSB = 0;
    localparam int CFG_LITTLE   = 2;
    localparam int CFG_CORR     = 3;
    localparam int CFG_WID_LSB  = 4;
    localparam int CFG_BRK0     = 6;
    localparam logic [6:0] CFG_RESET = 7'h0c;

    // =====================================================================
    // Boot methods and ROM widths
    typedef enum logic [1:0] {BOOT_HOST, BOOT_EMU, BOOT_ROM} bcl_boot_t;
    typedef enum logic [1:0] {WID_8, WID_16, WID_32} bcl_wid_t;

    // Narrow data sits on the top lanes only when big endian and uncorrected.
    function automatic logic use_top(input logic little, input logic corr_pin);
        return !little && corr_pin;
    endfunction

    function automatic logic [15:0] lane_get(input logic [31:0] d, input bcl_wid_t w,
                                             input logic little, input logic corr_pin);
        logic top;
        top = use_top(little, corr_pin);
        case (w)
            WID_8:   lane_get = top ? {8'h00, d[31:24]} : {8'h00, d[7:0]};
            WID_16:  lane_get = top ? d[31:16] : d[15:0];
            default: lane_get = d[15:0];
        endcase
    endfunction

    function automatic logic [31:0] lane_put(input logic [15:0] u, input bcl_wid_t w,
                                             input logic little, input logic corr_pin);
        logic top;
        top = use_top(little, corr_pin);
        case (w)
            WID_8:   lane_put = top ? {u[7:0], 24'h000000} : {24'h000000, u[7:0]};
            WID_16:  lane_put = top ? {u, 16'h0000} : {16'h0000, u};
            default: lane_put = {16'h0000, u};
        endcase
    endfunction

endpackage

// ---- rtl/bcl_if.sv ----
`timescale 1ns/1ps
interface bcl_if;
    bcl_pkg::bcl_boot_t   boot_sel;
    logic                 endian_select_pin;
    logic                 lane_correction_pin;
    bcl_pkg::bcl_wid_t    rom_width;
    logic                 brk0;
    logic                 hp_req;
    logic                 hp_we;
    logic                 hp_creg;
    logic [7:0]           hp_addr;
    logic [31:0]          hp_wdata;
    logic [31:0]          hp_rdata;
    logic                 hp_ack;
    logic                 emu_set;
    logic                 rom_rd;
    logic [10:0]          rom_addr;
    logic [31:0]          external_data_lines;
    logic                 rom_ack;

    modport dev (
        input  boot_sel, endian_select_pin, lane_correction_pin, rom_width, brk0,
        input  hp_req, hp_we, hp_creg, hp_addr, hp_wdata, emu_set,
        output hp_rdata, hp_ack,
        output rom_rd, rom_addr,
        input  external_data_lines, rom_ack
    );
    modport far (
        output boot_sel, endian_select_pin, lane_correction_pin, rom_width, brk0,
        output hp_req, hp_we, hp_creg, hp_addr, hp_wdata, emu_set,
        input  hp_rdata, hp_ack,
        input  rom_rd, rom_addr,
        output external_data_lines, rom_ack
    );
endinterface

// ---- rtl/bcl_pack.sv ----
`timescale 1ns/1ps
module bcl_pack (
    input  wire logic              clk_sys_i,
    input  wire logic              resetn_i,
    input  wire logic              clear_i,
    input  wire logic              valid_i,
    input  wire logic [15:0]       unit_i,
    input  wire logic [31:0]       full_i,
    input  wire bcl_pkg::bcl_wid_t width_i,
    input  wire logic              little_i,
    output logic [31:0]            word_o,
    output logic                   word_valid_o
);
    typedef struct packed {
        logic [31:0] acc;
        logic [1:0]  cnt;
        logic [31:0] word;
        logic        wv;
    } bcl_pack_st_t;

    bcl_pack_st_t s_r, s_nxt;

    // =====================================================================
    // Packing
    always_comb begin
        s_nxt = s_r;
        s_nxt.wv = 1'b0;
        if (clear_i) begin
            s_nxt.cnt = 2'h0;
        end else if (valid_i) begin
            // narrow units are gathered into whole words.
            // first unit is least significant when little endian.
            case (width_i)
                bcl_pkg::WID_8: begin
                    s_nxt.acc = little_i ? {unit_i[7:0], s_r.acc[31:8]}
                                         : {s_r.acc[23:0], unit_i[7:0]};
                    s_nxt.cnt = s_r.cnt + 2'h1;
                    s_nxt.wv  = (s_r.cnt == 2'h3);
                end
                bcl_pkg::WID_16: begin
                    s_nxt.acc = little_i ? {unit_i, s_r.acc[31:16]}
                                         : {s_r.acc[15:0], unit_i};
                    s_nxt.cnt = {1'b0, ~s_r.cnt[0]};
                    s_nxt.wv  = s_r.cnt[0];
                end
                default: begin
                    s_nxt.acc = full_i;
                    s_nxt.wv  = 1'b1;
                end
            endcase
            s_nxt.word = s_nxt.acc;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign word_o       = s_r.word;
    assign word_valid_o = s_r.wv;
endmodule

// ---- rtl/bcl_dev.sv ----
// Operation
// - endian pin picks mode, little by default.
// - uncorrected narrow data: low lanes little, top big.
// - 16-bit uses two upper or lower lanes.
// - correction pin low forces lowest lanes.
// - reset low holds all state but the memory array in reset state.
// - host, emulation or ROM boot, after reset.
// - host boot keeps CPU stalled, rest runs.
// - host sets interrupt bit when loading done.
// - interrupt bit in host boot releases CPU.
// - releasing interrupt is not left pending.
// - bit releases CPU only in host or emulation boot.
// - host may write and read all memory.
// - CPU clears bit; no new interrupts meanwhile.
// - emulator sets bit to release the CPU.
// - emulator breakpoint at zero halts first instruction.
// - ROM boot copies one kilobyte to zero.
// - narrow ROM units packed into 32-bit words.
// - copy ends, then CPU released at zero.
// - ROM stored in the system's byte order.
`timescale 1ns/1ps
module bcl_dev (
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    bcl_if.dev               lnk,
    input  wire logic        cpu_clr_i,
    input  wire logic        cpu_resume_i,
    input  wire logic [7:0]  cpu_addr_i,
    output logic [31:0]      cpu_rdata_o,
    output logic             cpu_stall_o,
    output logic             cpu_halt_o,
    output logic             cpu_irq_o,
    output logic             int_bit_o,
    output logic             little_o
);
    typedef enum logic [1:0] {PH_CFG, PH_STALL, PH_COPY, PH_RUN} bcl_phase_t;

    typedef struct packed {
        bcl_phase_t         ph;
        logic [1:0]         cfg_cnt;
        bcl_pkg::bcl_boot_t mode;
        logic               little;
        logic               corr;
        bcl_pkg::bcl_wid_t  wid;
        logic               int_bit;
        logic               irq;
        logic               halt;
        logic               stall;
        logic               rom_rd;
        logic [10:0]        rom_addr;
        logic [7:0]         widx;
        logic               hp_ack;
        logic [31:0]        hp_rdata;
        logic [31:0]        cpu_rdata;
    } bcl_dev_st_t;

    bcl_dev_st_t s_r, s_nxt;
    logic [31:0] mem [0:bcl_pkg::MEM_WORDS-1];
    logic        mem_we;
    logic [7:0]  mem_wa;
    logic [31:0] mem_wd;
    logic        set_req;
    logic        pk_clear;
    logic        pk_valid;
    logic [31:0] pk_word;
    logic        pk_wv;
    logic [15:0] unit;
    logic [10:0] step;

    assign pk_clear = (s_r.ph != PH_COPY);
    assign pk_valid = (s_r.ph == PH_COPY) && s_r.rom_rd && lnk.rom_ack;
    // the lane chosen depends on endian and correction straps.
    assign unit = bcl_pkg::lane_get(lnk.external_data_lines, s_r.wid, s_r.little, s_r.corr);
    assign step = (s_r.wid == bcl_pkg::WID_8) ? 11'h001 :
                  (s_r.wid == bcl_pkg::WID_16) ? 11'h002 : 11'h004;

    bcl_pack u_pack (
        .clk_sys_i    (clk_sys_i),
        .resetn_i     (resetn_i),
        .clear_i      (pk_clear),
        .valid_i      (pk_valid),
        .unit_i       (unit),
        .full_i       (lnk.external_data_lines),
        .width_i      (s_r.wid),
        .little_i     (s_r.little),
        .word_o       (pk_word),
        .word_valid_o (pk_wv)
    );

    // =====================================================================
    // Boot sequencing and host port
    always_comb begin
        s_nxt = s_r;
        s_nxt.hp_ack = 1'b0;
        mem_we = 1'b0;
        mem_wa = lnk.hp_addr;
        mem_wd = lnk.hp_wdata;
        s_nxt.cpu_rdata = mem[cpu_addr_i];
        set_req = 1'b0;

        case (s_r.ph)
            PH_CFG: begin
                // straps are caught while internal reset still holds.
                s_nxt.mode    = lnk.boot_sel;
                s_nxt.little  = lnk.endian_select_pin;
                s_nxt.corr    = lnk.lane_correction_pin;
                s_nxt.wid     = lnk.rom_width;
                s_nxt.cfg_cnt = s_r.cfg_cnt + 2'h1;
                if (s_r.cfg_cnt == bcl_pkg::CFG_SAMPLE_N) begin
                    // the method takes effect as internal reset ends.
                    s_nxt.ph = (s_r.mode == bcl_pkg::BOOT_ROM) ? PH_COPY : PH_STALL;
                end
            end
            PH_COPY: begin
                // one kilobyte is fetched from the start of the boot space.
                if (s_r.rom_rd && lnk.rom_ack) begin
                    s_nxt.rom_rd   = 1'b0;
                    s_nxt.rom_addr = s_r.rom_addr + step;
                end else if (!s_r.rom_rd && s_r.rom_addr != bcl_pkg::ROM_LAST) begin
                    s_nxt.rom_rd = 1'b1;
                end
                if (pk_wv) begin
                    s_nxt.widx = s_r.widx + 8'h01;
                    // the last word of the block frees the CPU.
                    if (s_r.widx == bcl_pkg::MEM_LAST) begin
                        s_nxt.ph   = PH_RUN;
                        s_nxt.halt = 1'b0;
                    end
                end
            end
            default: ;
        endcase

        if (pk_wv) begin
            mem_we = 1'b1;
            mem_wa = s_r.widx;
            mem_wd = pk_word;
        end else if (lnk.hp_req && !s_r.hp_ack && s_r.ph != PH_CFG) begin
            // the host reaches every word, both ways.
            s_nxt.hp_ack = 1'b1;
            if (lnk.hp_creg) begin
                s_nxt.hp_rdata = {31'h0, s_r.int_bit};
                set_req = lnk.hp_we && lnk.hp_wdata[bcl_pkg::HP_CTRL_BIT];
            end else begin
                mem_we = lnk.hp_we;
                s_nxt.hp_rdata = mem[lnk.hp_addr];
            end
        end

        // the emulator's set behaves like the host's.
        if (lnk.emu_set) begin
            set_req = 1'b1;
        end

        if (cpu_clr_i) begin
            s_nxt.int_bit = 1'b0;
            s_nxt.irq     = 1'b0;
        end
        if (cpu_resume_i) begin
            s_nxt.halt = 1'b0;
        end
        // a set is only seen while the bit is clear; set beats clear.
        if (set_req && !s_r.int_bit && s_r.ph != PH_CFG) begin
            s_nxt.int_bit = 1'b1;
            if (s_r.ph == PH_STALL) begin
                // release only for host style boots; no pending irq.
                if (s_r.mode != bcl_pkg::BOOT_ROM) begin
                    s_nxt.ph = PH_RUN;
                    // the emulator's breakpoint at zero stops the CPU.
                    s_nxt.halt = lnk.brk0;
                end
            end else if (s_r.ph == PH_RUN) begin
                s_nxt.irq = 1'b1;
            end
        end
        s_nxt.stall = (s_nxt.ph != PH_RUN);
    end

    // asynchronous reset puts every state bit to its reset value.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_r <= '0;
            s_r.little <= 1'b1;
            s_r.corr   <= 1'b1;
            s_r.stall  <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // The array has no reset; the boot copy or the host fills it.
    always_ff @(posedge clk_sys_i) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    assign lnk.rom_rd   = s_r.rom_rd;
    assign lnk.rom_addr = s_r.rom_addr;
    assign lnk.hp_ack   = s_r.hp_ack;
    assign lnk.hp_rdata = s_r.hp_rdata;
    // stalled until released, straps phase included.
    assign cpu_stall_o  = s_r.stall;
    assign cpu_halt_o   = s_r.halt;
    assign cpu_irq_o    = s_r.irq;
    assign cpu_rdata_o  = s_r.cpu_rdata;
    assign int_bit_o    = s_r.int_bit;
    // the caught endian strap is shown to the core.
    assign little_o     = s_r.little;
endmodule

// ---- rtl/bcl_far.sv ----
`timescale 1ns/1ps
module bcl_far (
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    bcl_if.far               lnk,
    input  wire logic [2:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest
);
    typedef struct packed {
        logic        wreq;
        logic [31:0] rdata;
        logic [6:0]  cfg;
        logic [9:0]  addr;
        logic [31:0] wdata;
        logic [31:0] hp_rd;
        logic        hp_req;
        logic        hp_we;
        logic        hp_creg;
        logic        emu;
        logic        rom_ack;
        logic [31:0] rom_dat;
    } bcl_far_st_t;

    bcl_far_st_t s_r, s_nxt;
    logic [7:0]  rom [0:bcl_pkg::ROM_BYTES-1];
    logic        rom_we;
    logic [15:0] u16;
    logic [9:0]  ra;

    // =====================================================================
    // Avalon slave, host port master and ROM model
    always_comb begin
        s_nxt = s_r;
        s_nxt.wreq    = 1'b1;
        s_nxt.emu     = 1'b0;
        s_nxt.rom_ack = 1'b0;
        rom_we = 1'b0;
        ra = lnk.rom_addr[9:0];
        // ROM bytes are kept in the configured byte order.
        u16 = s_r.cfg[bcl_pkg::CFG_LITTLE] ? {rom[ra + 10'h001], rom[ra]}
                                           : {rom[ra], rom[ra + 10'h001]};
        if ((avs_read || avs_write) && s_r.wreq) begin
            s_nxt.wreq = 1'b0;
            case (avs_address)
                bcl_pkg::REG_CTRL:  s_nxt.rdata = {31'h0, s_r.hp_req};
                bcl_pkg::REG_CFG:   s_nxt.rdata = {25'h0, s_r.cfg};
                bcl_pkg::REG_ADDR:  s_nxt.rdata = {22'h0, s_r.addr};
                bcl_pkg::REG_WDATA: s_nxt.rdata = s_r.wdata;
                bcl_pkg::REG_RDATA: s_nxt.rdata = s_r.hp_rd;
                bcl_pkg::REG_STAT:  s_nxt.rdata = {31'h0, s_r.hp_req};
                default:            s_nxt.rdata = 32'h00000000;
            endcase
            if (avs_write) begin
                case (avs_address)
                    bcl_pkg::REG_CTRL: begin
                        if (!s_r.hp_req) begin
                            s_nxt.hp_req  = avs_writedata[bcl_pkg::CTRL_HP_WRITE] |
                                            avs_writedata[bcl_pkg::CTRL_HP_READ];
                            s_nxt.hp_we   = avs_writedata[bcl_pkg::CTRL_HP_WRITE];
                            s_nxt.hp_creg = avs_writedata[bcl_pkg::CTRL_HP_CREG];
                        end
                        s_nxt.emu = avs_writedata[bcl_pkg::CTRL_EMU_SET];
                    end
                    bcl_pkg::REG_CFG:   s_nxt.cfg   = avs_writedata[6:0];
                    bcl_pkg::REG_ADDR:  s_nxt.addr  = avs_writedata[9:0];
                    bcl_pkg::REG_WDATA: s_nxt.wdata = avs_writedata;
                    bcl_pkg::REG_ROM: begin
                        rom_we = 1'b1;
                        s_nxt.addr = s_r.addr + 10'h001;
                    end
                    default: ;
                endcase
            end
        end
        // the device's ack ends the host port request and latches its read data.
        if (s_r.hp_req && lnk.hp_ack) begin
            s_nxt.hp_req = 1'b0;
            s_nxt.hp_rd  = lnk.hp_rdata;
        end
        if (lnk.rom_rd && !s_r.rom_ack) begin
            s_nxt.rom_ack = 1'b1;
            if (lnk.rom_width == bcl_pkg::WID_32) begin
                s_nxt.rom_dat = s_r.cfg[bcl_pkg::CFG_LITTLE] ?
                    {rom[ra + 10'h003], rom[ra + 10'h002], rom[ra + 10'h001], rom[ra]} :
                    {rom[ra], rom[ra + 10'h001], rom[ra + 10'h002], rom[ra + 10'h003]};
            end else begin
                s_nxt.rom_dat = bcl_pkg::lane_put(u16 >> ((lnk.rom_width == bcl_pkg::WID_8)
                                                  ? 8 : 0) & 16'hffff,
                                                  lnk.rom_width,
                                                  s_r.cfg[bcl_pkg::CFG_LITTLE],
                                                  s_r.cfg[bcl_pkg::CFG_CORR]);
                if (lnk.rom_width == bcl_pkg::WID_8) begin
                    s_nxt.rom_dat = bcl_pkg::lane_put({8'h00, rom[ra]}, lnk.rom_width,
                                                      s_r.cfg[bcl_pkg::CFG_LITTLE],
                                                      s_r.cfg[bcl_pkg::CFG_CORR]);
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_r <= '0;
            s_r.cfg <= bcl_pkg::CFG_RESET;
            s_r.wreq <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rom_we) begin
            rom[s_r.addr] <= avs_writedata[7:0];
        end
    end

    assign avs_readdata        = s_r.rdata;
    assign avs_waitrequest     = s_r.wreq;
    assign lnk.boot_sel        = bcl_pkg::bcl_boot_t'(s_r.cfg[1:0]);
    assign lnk.endian_select_pin   = s_r.cfg[bcl_pkg::CFG_LITTLE];
    assign lnk.lane_correction_pin = s_r.cfg[bcl_pkg::CFG_CORR];
    assign lnk.rom_width       = bcl_pkg::bcl_wid_t'(s_r.cfg[5:4]);
    // the emulator asks for a breakpoint at address zero.
    assign lnk.brk0            = s_r.cfg[bcl_pkg::CFG_BRK0];
    assign lnk.hp_req          = s_r.hp_req;
    assign lnk.hp_we           = s_r.hp_we;
    assign lnk.hp_creg         = s_r.hp_creg;
    assign lnk.hp_addr         = s_r.addr[7:0];
    assign lnk.hp_wdata        = s_r.wdata;
    assign lnk.emu_set         = s_r.emu;
    assign lnk.rom_ack         = s_r.rom_ack;
    assign lnk.external_data_lines = s_r.rom_dat;
endmodule

// ---- test/bcl_assertions.sv ----
`timescale 1ns/1ps
module bcl_assertions (
    input  wire logic               clk_sys_i,
    input  wire logic               resetn_i,
    input  wire bcl_pkg::bcl_boot_t boot_sel,
    input  wire bcl_pkg::bcl_wid_t  rom_width,
    input  wire logic               endian_select_pin,
    input  wire logic               lane_correction_pin,
    input  wire logic [31:0]        external_data_lines,
    input  wire logic               hp_req,
    input  wire logic               hp_ack,
    input  wire logic               rom_rd,
    input  wire logic [10:0]        rom_addr,
    input  wire logic               rom_ack,
    input  wire logic               cpu_stall_o,
    input  wire logic               cpu_irq_o,
    input  wire logic               int_bit_o,
    input  wire logic               little_o
);
    // =====================================================================
    // Helpers
    logic [10:0] acks_r;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    // Bytes fetched so far; restarting at reset makes it cover one boot copy.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            acks_r <= 11'h000;
        end else if (rom_ack) begin
            acks_r <= acks_r + (11'h001 << rom_width);
        end
    end
    // =====================================================================
    // Checks
    AST_ACK_PULSE: assert property (hp_ack |=> !hp_ack)
        else $error("host port ack too long");
    AST_ACK_REQ: assert property (hp_ack |-> hp_req)
        else $error("host port ack without request");
    AST_ROM_DROP: assert property (rom_ack |=> !rom_rd)
        else $error("rom read held after ack");
    AST_ROM_RANGE: assert property (rom_rd |-> rom_addr < bcl_pkg::ROM_LAST)
        else $error("rom read beyond one kilobyte");
    AST_ROM_STEP: assert property ($rose(rom_rd) |-> rom_addr == acks_r)
        else $error("rom address did not step by one unit");
    AST_LANES: assert property (rom_ack && rom_width != bcl_pkg::WID_32 |->
        ((!endian_select_pin && lane_correction_pin) ? external_data_lines[15:0] == 16'h0
                                                     : external_data_lines[31:16] == 16'h0))
        else $error("narrow rom data on wrong lanes");
    AST_ROM_DONE: assert property ($fell(cpu_stall_o) && boot_sel == bcl_pkg::BOOT_ROM
        |-> acks_r == 11'h400 && !rom_rd)
        else $error("rom boot released before full copy");
    AST_HOST_REL: assert property ($fell(cpu_stall_o) && boot_sel != bcl_pkg::BOOT_ROM
        |-> int_bit_o)
        else $error("stall released without interrupt bit");
    AST_IRQ_RUN: assert property ($rose(cpu_irq_o) |-> $past(cpu_stall_o) == 1'b0)
        else $error("interrupt pending from stalled phase");
    AST_ENDIAN: assert property (!cpu_stall_o |-> little_o == endian_select_pin)
        else $error("endian mode differs from pin");
    AST_STRAP_HOLD: assert property (!cpu_stall_o |-> $stable(little_o))
        else $error("endian strap changed while running");
    COV_HOST: cover property ($fell(cpu_stall_o) && boot_sel == bcl_pkg::BOOT_HOST);
    COV_EMU: cover property ($fell(cpu_stall_o) && boot_sel == bcl_pkg::BOOT_EMU);
    COV_ROM: cover property ($fell(cpu_stall_o) && boot_sel == bcl_pkg::BOOT_ROM);
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    // =====================================================================
    // Harness
    logic        clk_sys_i, resetn_i, cpu_clr_i, cpu_resume_i, avs_read, avs_write;
    logic        avs_waitrequest, cpu_stall_o, cpu_halt_o, cpu_irq_o, int_bit_o, little_o;
    logic [7:0]  cpu_addr_i;
    logic [2:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, cpu_rdata_o, rd;
    logic [31:0] cfgs [5] = '{32'h0a, 32'h02, 32'h0e, 32'h1a, 32'h2e};
    int          bad_count, tests_run;
    bcl_if bcl_if_inst ();
    bcl_dev bcl_dev_inst (.clk_sys_i, .resetn_i, .lnk(bcl_if_inst), .cpu_clr_i, .cpu_resume_i,
        .cpu_addr_i, .cpu_rdata_o, .cpu_stall_o, .cpu_halt_o, .cpu_irq_o, .int_bit_o, .little_o);
    bcl_far bcl_far_inst (.clk_sys_i, .resetn_i, .lnk(bcl_if_inst), .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
    bcl_assertions bcl_assertions_inst (.clk_sys_i, .resetn_i, .boot_sel(bcl_if_inst.boot_sel),
        .rom_width(bcl_if_inst.rom_width), .endian_select_pin(bcl_if_inst.endian_select_pin),
        .hp_req(bcl_if_inst.hp_req), .hp_ack(bcl_if_inst.hp_ack), .rom_rd(bcl_if_inst.rom_rd),
        .rom_addr(bcl_if_inst.rom_addr), .rom_ack(bcl_if_inst.rom_ack), .cpu_stall_o,
        .cpu_irq_o, .int_bit_o, .little_o,
        .lane_correction_pin(bcl_if_inst.lane_correction_pin),
        .external_data_lines(bcl_if_inst.external_data_lines));

    task automatic summarize();
        if (bad_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // A request raised with now set goes out on the current edge, as after reset release.
    task automatic avs(input logic wr, input logic [2:0] a, input logic [31:0] d, input bit now = 0);
        if (!now) begin
            @(posedge clk_sys_i);
        end
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do @(posedge clk_sys_i); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic hp(input logic [31:0] ctrl);
        avs(1'b1, bcl_pkg::REG_CTRL, ctrl);
        do avs(1'b0, bcl_pkg::REG_STAT, 32'h0); while (rd[0] !== 1'b0);
    endtask

    task automatic boot(input logic [31:0] cfg);
        @(posedge clk_sys_i);
        resetn_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        chk({cpu_stall_o, cpu_halt_o, cpu_irq_o, int_bit_o, little_o}, 32'h11);
        resetn_i <= 1'b1;
        avs(1'b1, bcl_pkg::REG_CFG, cfg, 1'b1);
        repeat (4) @(posedge clk_sys_i);
    endtask

    task automatic cpu_rd(input logic [7:0] a, input logic [31:0] exp);
        cpu_addr_i <= a;
        repeat (2) @(posedge clk_sys_i);
        chk(cpu_rdata_o, exp);
    endtask

    function automatic logic [7:0] rb(input int i);
        return 8'(i * 37 + i / 256 + 5);
    endfunction

    function automatic logic [31:0] rw(input int w, input logic lit);
        int b;
        b = 4 * w;
        return lit ? {rb(b + 3), rb(b + 2), rb(b + 1), rb(b)} : {rb(b), rb(b + 1), rb(b + 2), rb(b + 3)};
    endfunction

    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    initial begin
        #1500000;
        bad_count++;
        summarize();
    end

    initial begin
        {resetn_i, cpu_clr_i, cpu_resume_i, avs_read, avs_write} = 5'h00;
        {cpu_addr_i, avs_address, avs_writedata} = '0;
        bad_count = 0;
        tests_run = 0;
        boot(32'h0c);
        chk(little_o, 1'b1);
        avs(1'b1, bcl_pkg::REG_ADDR, 32'h0);
        for (int i = 0; i < bcl_pkg::ROM_BYTES; i++) begin
            avs(1'b1, bcl_pkg::REG_ROM, {24'h0, rb(i)});
        end
        for (int k = 0; k < 2; k++) begin
            avs(1'b1, bcl_pkg::REG_ADDR, k ? 32'hff : 32'h0);
            avs(1'b1, bcl_pkg::REG_WDATA, 32'hc3a50000 + k);
            hp(32'h1);
            hp(32'h2);
            avs(1'b0, bcl_pkg::REG_RDATA, 32'h0);
            chk(rd, 32'hc3a50000 + k);
        end
        chk(cpu_stall_o, 1'b1);
        avs(1'b1, bcl_pkg::REG_WDATA, 32'h1);
        hp(32'h5);
        chk({cpu_stall_o, cpu_halt_o, cpu_irq_o, int_bit_o}, 32'h1);
        cpu_rd(8'hff, 32'hc3a50001);
        hp(32'h5);
        chk(cpu_irq_o, 1'b0);
        cpu_clr_i <= 1'b1;
        @(posedge clk_sys_i);
        cpu_clr_i <= 1'b0;
        hp(32'h5);
        chk({cpu_irq_o, int_bit_o}, 32'h3);
        boot(32'h4d);
        chk(cpu_stall_o, 1'b1);
        avs(1'b1, bcl_pkg::REG_CTRL, 32'h8);
        repeat (2) @(posedge clk_sys_i);
        chk({cpu_stall_o, cpu_halt_o}, 32'h1);
        cpu_resume_i <= 1'b1;
        @(posedge clk_sys_i);
        cpu_resume_i <= 1'b0;
        @(posedge clk_sys_i);
        chk(cpu_halt_o, 1'b0);
        for (int c = 0; c < 5; c++) begin
            boot(cfgs[c]);
            avs(1'b1, bcl_pkg::REG_WDATA, 32'h1);
            hp(32'h5);
            chk(cpu_stall_o, 1'b1);
            for (int n = 0; n < 9000 && cpu_stall_o !== 1'b0; n++) begin
                @(posedge clk_sys_i);
            end
            chk(cpu_stall_o, 1'b0);
            for (int w = 0; w < 256; w += 85) begin
                cpu_rd(8'(w), rw(w, cfgs[c][2]));
            end
        end
        summarize();
    end
endmodule
